// >>> hw/cscic_pkg.sv
package cscic_pkg;

    // Register offsets: socket base relative and legacy per-socket offsets.
    localparam logic [11:0] CSCIC_CFG_OFFSET = 12'h805;
    localparam logic [7:0] CSCIC_LEGACY_A_OFFSET = 8'h05;
    localparam logic [7:0] CSCIC_LEGACY_B_OFFSET = 8'h45;
    localparam logic [7:0] CSCIC_STATUS_A_OFFSET = 8'h04;
    localparam logic [7:0] CSCIC_STATUS_B_OFFSET = 8'h44;

    // Field positions inside the configuration register.
    localparam int CSCIC_ROUTE_LSB = 4;
    localparam int CSCIC_DETECT_BIT = 3;
    localparam int CSCIC_READY_BIT = 2;
    localparam int CSCIC_BATLOW_BIT = 1;
    localparam int CSCIC_BATDEAD_BIT = 0;

    // Reset values.
    localparam logic [7:0] CSCIC_CFG_RESET = 8'h00;
    localparam logic [3:0] CSCIC_STATUS_RESET = 4'h0;

    // Routing codes.
    localparam logic [3:0] CSCIC_ROUTE_NONE = 4'h0;
    localparam logic [3:0] CSCIC_ROUTE_SMI = 4'h2;

    // Register access request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cscic_req_type;

    // Card-side event inputs of one socket.
    typedef struct packed {
        logic card_detect_a;
        logic card_detect_b;
        logic ready;
        logic battery_low;
        logic battery_dead;
    } cscic_card_type;

endpackage

// >>> hw/cscic_socket.sv
`timescale 1ns/1ns
// One socket: enable bits, routing field and sticky change flags.
module cscic_socket (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctx_rst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    input wire logic stat_rd,
    input wire logic stat_wr,
    input wire logic [7:0] stat_wdata,
    input wire logic clear_by_write,
    input wire logic [3:0] events,
    output logic [7:0] cfg_q,
    output logic [3:0] stat_q
);

    logic [7:0] cfg_d;
    logic [3:0] stat_d;
    logic [3:0] en;
    logic [3:0] clr;

    // Next values: enables steer the sticky flags; set wins over clear.
    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr) begin
            cfg_d = cfg_wdata;
        end
        en = cfg_q[3:0];
        clr = 4'h0;
        if (clear_by_write && stat_wr) begin
            clr = stat_wdata[3:0];
        end else if (!clear_by_write && stat_rd) begin
            clr = 4'hF;
        end
        stat_d = ((stat_q & ~clr) | events) & en;
        // The context reset clears enables and flags but keeps the routing field.
        if (ctx_rst) begin
            cfg_d[3:0] = cscic_pkg::CSCIC_CFG_RESET[3:0];
            stat_d = cscic_pkg::CSCIC_STATUS_RESET;
        end
    end

    // Power-on reset clears the whole register; otherwise the next values load.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= cscic_pkg::CSCIC_CFG_RESET;
            stat_q <= cscic_pkg::CSCIC_STATUS_RESET;
        end else begin
            cfg_q <= cfg_d;
            stat_q <= stat_d;
        end
    end

endmodule

// >>> hw/cscic_top.sv
`timescale 1ns/1ns
// How it works
// - Bits 7 to 4 pick the destination line for the combined change interrupt.
// - Code zero with the diagnostic route bit set sends changes to the bus interrupt.
// - Code zero with that bit clear drives no legacy line; bus path only if route bit is one.
// - Each nonzero code but 2 drives one legacy output; code 2 drives the management interrupt instead.
// - Bit 3 unmasks a change on either card detect line.
// - Bit 2 unmasks a rising edge on the card ready signal.
// - Bit 1 unmasks a rising edge on the battery low signal.
// - Bit 0 unmasks a rising edge on the battery dead signal.
// - The eight bit register reads and writes freely and resets to zero.
// - With power events on, only global reset clears the enables; else either reset.
// - Each of the two sockets has its own copy at legacy offsets 05h and 45h.
// - A masked source always reads as zero in the status register.
// - Pending flags clear by a read or by writing ones, as the clear mode bit says.
module cscic_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic global_reset,
    input wire logic bus_reset,
    input wire logic power_mgmt_event,
    input wire logic diag_route_bit,
    input wire logic gen_route_bit,
    input wire logic clear_by_write,
    input wire cscic_pkg::cscic_req_type req,
    input wire cscic_pkg::cscic_card_type card_a,
    input wire cscic_pkg::cscic_card_type card_b,
    output logic [7:0] rdata_q,
    output logic [15:0] legacy_irq_q,
    output logic system_mgmt_irq_q,
    output logic bus_irq_q
);

    logic rst_s1_q;
    logic rst_s2_q;

    // Reset release through two flip-flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops per card pin, then a history flop for edges.
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    logic [NPIN-1:0] pin_h_q;
    logic [NPIN-1:0] pin_s1_d;
    logic [NPIN-1:0] pin_s2_d;
    logic [NPIN-1:0] pin_h_d;
    logic [2:0] ctl_s1_q;
    logic [2:0] ctl_s2_q;

    assign pin_raw = {card_a, card_b};

    // Next values of the synchroniser chain.
    always_comb begin
        pin_s1_d = pin_raw;
        pin_s2_d = pin_s1_q;
        pin_h_d = pin_s2_q;
    end

    // Registers of the synchroniser chain.
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_h_q <= '0;
            ctl_s1_q <= 3'h0;
            ctl_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_h_q <= pin_h_d;
            ctl_s1_q <= {global_reset, bus_reset, power_mgmt_event};
            ctl_s2_q <= ctl_s1_q;
        end
    end

    // Turns one socket's synchronised pins into event pulses.
    function automatic logic [3:0] events_of(input logic [4:0] now, input logic [4:0] was);
        logic [3:0] ev;
        ev[cscic_pkg::CSCIC_DETECT_BIT] = (now[4] ^ was[4]) | (now[3] ^ was[3]);
        ev[cscic_pkg::CSCIC_READY_BIT] = now[2] & ~was[2];
        ev[cscic_pkg::CSCIC_BATLOW_BIT] = now[1] & ~was[1];
        ev[cscic_pkg::CSCIC_BATDEAD_BIT] = now[0] & ~was[0];
        return ev;
    endfunction

    logic [3:0] ev_a;
    logic [3:0] ev_b;
    logic ctx_rst;

    // Global reset always clears context; bus reset only without power events.
    always_comb begin
        ev_a = events_of(pin_s2_q[9:5], pin_h_q[9:5]);
        ev_b = events_of(pin_s2_q[4:0], pin_h_q[4:0]);
        ctx_rst = ctl_s2_q[2] | (ctl_s2_q[1] & ~ctl_s2_q[0]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode for the two sockets.
    logic wr_cfg_a;
    logic wr_cfg_b;
    logic rd_st_a;
    logic rd_st_b;
    logic wr_st_a;
    logic wr_st_b;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [3:0] st_a;
    logic [3:0] st_b;
    logic [7:0] rdata_d;

    // Address strobes per socket.
    always_comb begin
        wr_cfg_a = req.wr && req.addr == cscic_pkg::CSCIC_LEGACY_A_OFFSET;
        wr_cfg_b = req.wr && req.addr == cscic_pkg::CSCIC_LEGACY_B_OFFSET;
        rd_st_a = req.rd && req.addr == cscic_pkg::CSCIC_STATUS_A_OFFSET;
        rd_st_b = req.rd && req.addr == cscic_pkg::CSCIC_STATUS_B_OFFSET;
        wr_st_a = req.wr && req.addr == cscic_pkg::CSCIC_STATUS_A_OFFSET;
        wr_st_b = req.wr && req.addr == cscic_pkg::CSCIC_STATUS_B_OFFSET;
        rdata_d = 8'h00;
        if (req.addr == cscic_pkg::CSCIC_LEGACY_A_OFFSET) begin
            rdata_d = cfg_a;
        end else if (req.addr == cscic_pkg::CSCIC_LEGACY_B_OFFSET) begin
            rdata_d = cfg_b;
        end else if (req.addr == cscic_pkg::CSCIC_STATUS_A_OFFSET) begin
            rdata_d = {4'h0, st_a};
        end else if (req.addr == cscic_pkg::CSCIC_STATUS_B_OFFSET) begin
            rdata_d = {4'h0, st_b};
        end
    end

    cscic_socket u_sock_a (
        .clk(clk),
        .rst_n(rst_s2_q),
        .ctx_rst(ctx_rst),
        .cfg_wr(wr_cfg_a),
        .cfg_wdata(req.wdata),
        .stat_rd(rd_st_a),
        .stat_wr(wr_st_a),
        .stat_wdata(req.wdata),
        .clear_by_write(clear_by_write),
        .events(ev_a),
        .cfg_q(cfg_a),
        .stat_q(st_a)
    );

    cscic_socket u_sock_b (
        .clk(clk),
        .rst_n(rst_s2_q),
        .ctx_rst(ctx_rst),
        .cfg_wr(wr_cfg_b),
        .cfg_wdata(req.wdata),
        .stat_rd(rd_st_b),
        .stat_wr(wr_st_b),
        .stat_wdata(req.wdata),
        .clear_by_write(clear_by_write),
        .events(ev_b),
        .cfg_q(cfg_b),
        .stat_q(st_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt routing of both sockets onto the output lines.
    logic [15:0] legacy_d;
    logic smi_d;
    logic bus_d;

    // Decodes one socket's route code and request into line drives.
    function automatic logic [17:0] route_of(input logic [3:0] code, input logic pend,
                                             input logic diag, input logic gen);
        logic [17:0] r;
        r = 18'h00000;
        if (code == cscic_pkg::CSCIC_ROUTE_NONE) begin
            r[17] = pend & (diag | gen);
        end else if (code == cscic_pkg::CSCIC_ROUTE_SMI) begin
            r[16] = pend;
        end else begin
            r[code] = pend;
        end
        return r;
    endfunction

    // Combined request is the OR of the unmasked flags of each socket.
    always_comb begin
        logic [17:0] ra;
        logic [17:0] rb;
        ra = route_of(cfg_a[7:4], |st_a, diag_route_bit, gen_route_bit);
        rb = route_of(cfg_b[7:4], |st_b, diag_route_bit, gen_route_bit);
        legacy_d = ra[15:0] | rb[15:0];
        smi_d = ra[16] | rb[16];
        bus_d = ra[17] | rb[17];
    end

    // Output registers.
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            rdata_q <= 8'h00;
            legacy_irq_q <= 16'h0000;
            system_mgmt_irq_q <= 1'b0;
            bus_irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            legacy_irq_q <= legacy_d;
            system_mgmt_irq_q <= smi_d;
            bus_irq_q <= bus_d;
        end
    end

endmodule

// >>> sim/cscic_top_sva.sv
`timescale 1ns/1ns
// Checks routing and register reads at the top module's ports.
module cscic_top_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic diag_route_bit,
    input wire logic gen_route_bit,
    input wire cscic_pkg::cscic_req_type req,
    input wire logic [7:0] rdata_q,
    input wire logic [15:0] legacy_irq_q,
    input wire logic system_mgmt_irq_q,
    input wire logic bus_irq_q
);
    cscic_pkg::cscic_req_type req_q;
    logic [3:0] ra_q, ra_d, rb_q, rb_d;
    logic [15:0] sel;
    // Routing shadows trail a write by one cycle, as the outputs do.
    always_comb begin
        ra_d = (req_q.wr && req_q.addr == 8'h05) ? req_q.wdata[7:4] : ra_q;
        rb_d = (req_q.wr && req_q.addr == 8'h45) ? req_q.wdata[7:4] : rb_q;
        sel = (16'h0001 << ra_q) | (16'h0001 << rb_q);
    end
    // Registers the shadows.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
            ra_q <= 4'h0;
            rb_q <= 4'h0;
        end else begin
            req_q <= req;
            ra_q <= ra_d;
            rb_q <= rb_d;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    legacy_route_a: assert property ((legacy_irq_q & ~sel) == 16'h0000)
        else $error("legacy line without its code");
    no_zero_line_a: assert property (!legacy_irq_q[0] && !legacy_irq_q[2])
        else $error("line 0 or 2 driven");
    smi_route_a: assert property (system_mgmt_irq_q |-> ra_q == 4'h2 || rb_q == 4'h2)
        else $error("management irq without its code");
    bus_route_a: assert property (bus_irq_q |-> (ra_q == 4'h0 || rb_q == 4'h0) &&
        ($past(diag_route_bit) || $past(gen_route_bit))) else $error("bad bus irq");
    reset_idle_a: assert property ($rose(rst_n) |-> ##1 legacy_irq_q == 16'h0000 &&
        !system_mgmt_irq_q && !bus_irq_q && rdata_q == 8'h00) else $error("not idle");
    cfg_readback_a: assert property ((req.wr && req.addr[5:0] == 6'h05) ##1
        (req.addr == $past(req.addr) && !req.wr) |=> rdata_q[7:4] == $past(req.wdata[7:4], 2))
        else $error("route field readback wrong");
    unmapped_zero_a: assert property (!(req.addr inside {8'h04, 8'h05, 8'h44, 8'h45})
        |=> rdata_q == 8'h00) else $error("unmapped read not zero");
    stat_upper_a: assert property (req.addr == 8'h04 || req.addr == 8'h44
        |=> rdata_q[7:4] == 4'h0) else $error("status upper bits set");
endmodule
bind cscic_top cscic_top_sva cscic_top_sva_inst (.clk, .rst_n, .diag_route_bit,
    .gen_route_bit, .req, .rdata_q, .legacy_irq_q, .system_mgmt_irq_q, .bus_irq_q);

// >>> sim/cscic_card_model.sv
`timescale 1ns/1ns
// Card pins of both sockets.
module cscic_card_model (
    input wire logic clk,
    output cscic_pkg::cscic_card_type card_a,
    output cscic_pkg::cscic_card_type card_b
);
    // Pins start low.
    initial begin
        card_a = '0;
        card_b = '0;
    end
    // Flips one pin twice, so a rising-edge source sees exactly one rise.
    task automatic fire(input logic sock, input int idx);
        repeat (2) begin
            @(posedge clk);
            if (sock) begin
                card_b[idx] <= ~card_b[idx];
            end else begin
                card_a[idx] <= ~card_a[idx];
            end
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// >>> sim/test_cscic_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
// Drives the block through its register port and card pins.
module test_cscic_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic global_reset = 1'b0, bus_reset = 1'b0, power_mgmt_event = 1'b0;
    logic diag_route_bit = 1'b0, gen_route_bit = 1'b0, clear_by_write = 1'b0;
    cscic_pkg::cscic_req_type req = '0;
    cscic_pkg::cscic_card_type card_a, card_b;
    logic [7:0] rdata_q;
    logic [15:0] legacy_irq_q;
    logic system_mgmt_irq_q, bus_irq_q;
    int compares = 0, n_mismatch = 0;
    cscic_top cscic_top_inst (.clk, .rst_n, .global_reset, .bus_reset, .power_mgmt_event,
        .diag_route_bit, .gen_route_bit, .clear_by_write, .req, .card_a, .card_b,
        .rdata_q, .legacy_irq_q, .system_mgmt_irq_q, .bus_irq_q);
    cscic_card_model cscic_card_model_inst (.clk, .card_a, .card_b);
    // Clock of 50 ns.
    initial begin
        forever #25 clk = ~clk;
    end
    // One access; returns on the edge that takes it, with the address still up.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
    endtask
    // Reads at the falling edge, while the registered read data stands.
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        @(negedge clk);
        `CHK(rdata_q, e)
    endtask
    // Checks the lines mid-cycle and returns on a rising edge for the next drive.
    task automatic ochk(input logic [15:0] l, input logic s, input logic b);
        @(negedge clk);
        `CHK(legacy_irq_q, l)
        `CHK(system_mgmt_irq_q, s)
        `CHK(bus_irq_q, b)
        @(posedge clk);
    endtask
    // Routes a change on either detect line of socket A and clears it by a write of one.
    task automatic route(input logic [3:0] c, input logic dg, input logic gn);
        diag_route_bit <= dg;
        gen_route_bit <= gn;
        acc(1'b1, 8'h05, {c, 4'h8});
        cscic_card_model_inst.fire(1'b0, c[0] ? 3 : 4);
        ochk((c == 4'h0 || c == 4'h2) ? 16'h0000 : 16'h0001 << c, c == 4'h2, c == 4'h0 && (dg || gn));
        rchk(8'h04, 8'h08);
        acc(1'b1, 8'h04, 8'h08);
        repeat (3) @(posedge clk);
        ochk(16'h0000, 1'b0, 1'b0);
    endtask
    // Pulses one of the two context resets.
    task automatic ctx(input logic g);
        repeat (3) @(posedge clk);
        global_reset <= g;
        bus_reset <= !g;
        repeat (4) @(posedge clk);
        global_reset <= 1'b0;
        bus_reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
    // Test sequence.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rchk(8'h05, 8'h00);
        rchk(8'h45, 8'h00);
        acc(1'b1, 8'h05, 8'hA5);
        acc(1'b1, 8'h45, 8'h3C);
        rchk(8'h05, 8'hA5);
        rchk(8'h45, 8'h3C);
        acc(1'b1, 8'h06, 8'hFF);
        rchk(8'h06, 8'h00);
        acc(1'b1, 8'h45, 8'h00);
        clear_by_write <= 1'b1;
        for (int i = 1; i < 16; i++) route(4'(i), 1'b0, 1'b0);
        route(4'h0, 1'b1, 1'b0);
        route(4'h0, 1'b0, 1'b1);
        route(4'h0, 1'b0, 1'b0);
        clear_by_write <= 1'b0;
        for (int b = 0; b < 3; b++) begin
            acc(1'b1, 8'h45, 8'h10);
            cscic_card_model_inst.fire(1'b1, b);
            ochk(16'h0000, 1'b0, 1'b0);
            rchk(8'h44, 8'h00);
            acc(1'b1, 8'h45, 8'h10 | (8'h01 << b));
            cscic_card_model_inst.fire(1'b1, b);
            ochk(16'h0002, 1'b0, 1'b0);
            rchk(8'h44, 8'h01 << b);
            rchk(8'h44, 8'h00);
        end
        acc(1'b1, 8'h05, 8'h3F);
        power_mgmt_event <= 1'b1;
        ctx(1'b0);
        rchk(8'h05, 8'h3F);
        ctx(1'b1);
        rchk(8'h05, 8'h30);
        acc(1'b1, 8'h05, 8'h3F);
        power_mgmt_event <= 1'b0;
        ctx(1'b0);
        rchk(8'h05, 8'h30);
        results();
    end
endmodule
